/* core/adcsc_regs.vh */
/*
 * constants of the serial conversion control block: word layout of the
 * serial input word, mode word defaults, timing figures and fifo sizing.
 * assumes it is included once per file by its bare name.
 */
`ifndef ADCSC_REGS_VH
`define ADCSC_REGS_VH

// serial word layout
`define ADCSC_WORD_W 16
`define ADCSC_FRAME_BITS 5'h10
`define ADCSC_CNT_MAX 5'h1F
`define ADCSC_BIT_REGSEL 15
`define ADCSC_CFG_ADDR_HI 14
`define ADCSC_CFG_ADDR_LO 11
`define ADCSC_CFG_DATA_HI 10

// mode word fields
`define ADCSC_MODE_SCAN_HI 14
`define ADCSC_MODE_SCAN_LO 11
`define ADCSC_MODE_CHAN_HI 10
`define ADCSC_MODE_CHAN_LO 7
`define ADCSC_MODE_RST_HI 6
`define ADCSC_MODE_RST_LO 5
`define ADCSC_MODE_TAG 2
`define ADCSC_MODE_SOFT_CONVERT_BIT 1
`define ADCSC_MODE_RESET 16'h0800
`define ADCSC_SCAN_MANUAL 4'h1
`define ADCSC_RST_SOFT 2'h2

// timing: system clock, internal oscillator, soft start delay
`define ADCSC_CLK_NS 100
`define ADCSC_OSC_NS 25
`define ADCSC_CONV_OSC 16
`define ADCSC_CONV_CYC ((`ADCSC_OSC_NS * `ADCSC_CONV_OSC + `ADCSC_CLK_NS - 1) / `ADCSC_CLK_NS)
`define ADCSC_SOFT_CONVERT_BIT_DELAY_NS 500
`define ADCSC_SOFT_CONVERT_BIT_CYC ((`ADCSC_SOFT_CONVERT_BIT_DELAY_NS + `ADCSC_CLK_NS - 1) / `ADCSC_CLK_NS)

// result fifo
`define ADCSC_FIFO_AW 4
`define ADCSC_FIFO_FULL 5'h10

`endif

/* core/adcsc_mem.v */
/*
 * result storage of the conversion control block: sixteen 16-bit words,
 * one write port, one read port whose data come out of a register.
 * assumes a single clock and that the caller keeps its own pointers.
 */
`include "adcsc_regs.vh"

module adcsc_mem (
   clk_sys,
   wr_en,
   wr_addr,
   wr_data,
   rd_addr,
   rd_data_ff
);
   input wire clk_sys;                          // system clock
   input wire wr_en;                            // write strobe
   input wire [`ADCSC_FIFO_AW-1:0] wr_addr;     // write location
   input wire [`ADCSC_WORD_W-1:0] wr_data;      // word to store
   input wire [`ADCSC_FIFO_AW-1:0] rd_addr;     // read location
   output reg [`ADCSC_WORD_W-1:0] rd_data_ff;   // registered read data

   // storage array, no reset: contents are only read behind a count
   reg [`ADCSC_WORD_W-1:0] mem [0:(1<<`ADCSC_FIFO_AW)-1];

   // write port
   always @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read port: one cycle latency, always reading
   always @(posedge clk_sys) begin
      rd_data_ff <= mem[rd_addr];
   end
endmodule // adcsc_mem

/* core/adcsc_top.v */
/*
 * serial conversion control: 4-wire serial frame engine, output word
 * formats, external-clock sequencing, internally timed scans with an
 * end-of-conversion flag, and a 16-entry result fifo that overwrites.
 * assumes the analog core answers ana_code/ana_below for ana_chan in the
 * same clock domain; sclk, cs_n, din and convert_start_n are pins.
 */
`include "adcsc_regs.vh"

module adcsc_top (
   clk_sys,
   reset,
   sclk,
   cs_n,
   din,
   convert_start_n,
   ana_code,
   ana_below,
   ana_bipolar,
   res_10bit,
   dout_ff,
   dout_oe_ff,
   eoc_n_ff,
   ana_chan_ff,
   ana_sample_ff,
   cfg_wr_ff,
   cfg_addr_ff,
   cfg_data_ff,
   mode_word_ff
);
   input wire clk_sys;                 // 10 MHz system clock
   input wire reset;                   // asynchronous, active high
   input wire sclk;                    // serial clock pin, idles high
   input wire cs_n;                    // chip select pin
   input wire din;                     // serial data in pin
   input wire convert_start_n;         // conversion start pin
   input wire [11:0] ana_code;         // raw result for ana_chan
   input wire ana_below;               // positive input below negative
   input wire ana_bipolar;             // channel configured bipolar
   input wire res_10bit;               // ten-bit variant strap
   output reg dout_ff;                 // serial data out
   output reg dout_oe_ff;              // dout driven while high
   output reg eoc_n_ff;                // end of conversion, low active
   output reg [3:0] ana_chan_ff;       // channel steering the mux
   output reg ana_sample_ff;           // one-cycle sample pulse
   output reg cfg_wr_ff;               // configuration word strobe
   output reg [3:0] cfg_addr_ff;       // configuration register index
   output reg [10:0] cfg_data_ff;      // configuration payload
   output reg [15:0] mode_word_ff;     // mode control word as held

   // scan engine states, one-hot
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_DELAY = 3'h2;
   localparam [2:0] ST_CONV = 3'h4;
   localparam integer CONV_N = `ADCSC_CONV_CYC;      // cycles per conversion
   localparam integer SOFT_CONVERT_BIT_N = `ADCSC_SOFT_CONVERT_BIT_CYC;    // cycles of soft start delay
   localparam [3:0] CONV_CYC = CONV_N[3:0];          // both fit the 4-bit timer
   localparam [3:0] SOFT_CONVERT_BIT_CYC = SOFT_CONVERT_BIT_N[3:0];
   // format a raw code: clamp and truncate as the converter reports it
   function [11:0] fmt_code;
      input [11:0] code;
      input below;
      input bipolar;
      input ten_bit;
      reg [11:0] val;
      begin
         val = code;                                   // two's complement kept
         if (!bipolar && below) begin
            val = 12'h000;
         end
         if (ten_bit) begin
            val = {val[11:2], 2'h0};
         end
         fmt_code = val;
      end
   endfunction

   // pin synchronisers: stage one feeds stage two only
   reg sclk_m_ff, sclk_s_ff, sclk_d_ff;
   reg cs_m_ff, cs_s_ff, cs_d_ff;
   reg din_m_ff, din_s_ff;
   reg cnv_m_ff, cnv_s_ff, cnv_d_ff;
   // frame engine state
   reg [4:0] rise_cnt_ff;              // rising edges seen this frame
   reg [15:0] shift_in_ff;             // first sixteen bits captured
   reg [15:0] ext_word_ff;             // external mode output word
   reg [3:0] ext_chan_ff;              // channel named by the last mode word frame that was not a soft reset
   reg byte_hi_ff;                     // next fifo byte is the high one
   // scan engine state
   reg [2:0] state_ff;
   reg [3:0] timer_ff;                 // conversion or delay count
   reg [3:0] scan_chan_ff;             // channel being converted
   // fifo pointers
   reg [3:0] wptr_ff;
   reg [3:0] rptr_ff;
   reg [4:0] count_ff;
   wire [15:0] rd_word;
   // edge detects on synchronised stages
   wire sclk_rise = sclk_s_ff & ~sclk_d_ff;
   wire sclk_fall = ~sclk_s_ff & sclk_d_ff;
   wire cs_fall = ~cs_s_ff & cs_d_ff;
   wire cs_rise = cs_s_ff & ~cs_d_ff;
   wire cnv_fall = ~cnv_s_ff & cnv_d_ff;
   wire in_frame = ~cs_s_ff;
   // mode word decode
   wire int_mode = (mode_word_ff[`ADCSC_MODE_SCAN_HI:`ADCSC_MODE_SCAN_LO]
                   != `ADCSC_SCAN_MANUAL);
   wire tag_en = mode_word_ff[`ADCSC_MODE_TAG];
   wire [3:0] last_chan = mode_word_ff[`ADCSC_MODE_CHAN_HI:`ADCSC_MODE_CHAN_LO];
   wire fifo_empty = (count_ff == 5'h00);
   wire fifo_full = (count_ff == `ADCSC_FIFO_FULL);

   // words finished at chip select rise
   wire word_done = cs_rise && (rise_cnt_ff >= `ADCSC_FRAME_BITS);
   wire is_mode_wr = word_done && !shift_in_ff[`ADCSC_BIT_REGSEL];
   wire is_cfg_wr = word_done && shift_in_ff[`ADCSC_BIT_REGSEL];
   wire soft_rst = is_mode_wr &&
      (shift_in_ff[`ADCSC_MODE_RST_HI:`ADCSC_MODE_RST_LO] == `ADCSC_RST_SOFT);

   // external mode word built at frame start from the analog core
   wire [11:0] ext_code = fmt_code(ana_code, ana_below, ana_bipolar, res_10bit);
   wire [15:0] ext_word_nxt = tag_en ? {ext_chan_ff, ext_code}
                                     : {1'b0, ext_code, 3'h0};

   // internal scan completion and fifo traffic
   wire conv_end = (state_ff == ST_CONV) && (timer_ff == CONV_CYC - 4'h1);
   wire scan_done = conv_end && (scan_chan_ff == last_chan);
   wire push = conv_end;
   wire [11:0] int_code = fmt_code(ana_code, ana_below, ana_bipolar, res_10bit);
   wire [15:0] push_word = {scan_chan_ff, int_code};
   // a byte is used up on the rise that completes its eighth bit
   wire byte_used = in_frame && sclk_rise && int_mode && !fifo_empty &&
                    (rise_cnt_ff[2:0] == 3'h7);
   wire pop = byte_used && !byte_hi_ff;

   // serial output bit for a given bit index
   reg nxt_bit;
   reg [7:0] cur_byte;
   always @* begin
      cur_byte = byte_hi_ff ? rd_word[15:8] : rd_word[7:0];
      nxt_bit = 1'b0;
      if (int_mode && !fifo_empty) begin
         nxt_bit = cur_byte[3'h7 - rise_cnt_ff[2:0]];
      end else if (!int_mode && (rise_cnt_ff < `ADCSC_FRAME_BITS)) begin
         nxt_bit = ext_word_ff[4'hF - rise_cnt_ff[3:0]];
      end
   end
   // result storage
   adcsc_mem adcsc_mem_inst (
      .clk_sys(clk_sys),
      .wr_en(push),
      .wr_addr(wptr_ff),
      .wr_data(push_word),
      .rd_addr(rptr_ff),
      .rd_data_ff(rd_word)
   );

   // two-flop synchronisers plus one history stage for edges
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         {sclk_d_ff, sclk_s_ff, sclk_m_ff} <= 3'h7;
         {cs_d_ff, cs_s_ff, cs_m_ff} <= 3'h7;
         {din_s_ff, din_m_ff} <= 2'h0;
         {cnv_d_ff, cnv_s_ff, cnv_m_ff} <= 3'h7;
      end else begin
         {sclk_d_ff, sclk_s_ff, sclk_m_ff} <= {sclk_s_ff, sclk_m_ff, sclk};
         {cs_d_ff, cs_s_ff, cs_m_ff} <= {cs_s_ff, cs_m_ff, cs_n};
         {din_s_ff, din_m_ff} <= {din_m_ff, din};
         {cnv_d_ff, cnv_s_ff, cnv_m_ff} <= {cnv_s_ff, cnv_m_ff, convert_start_n};
      end
   end

   // frame engine: capture on rise, drive on fall, release when idle
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rise_cnt_ff <= 5'h00;
         shift_in_ff <= 16'h0000;
         ext_word_ff <= 16'h0000;
         {dout_ff, dout_oe_ff} <= 2'h0;
      end else begin
         dout_oe_ff <= in_frame;
         if (cs_fall) begin
            // new frame: restart the count and show the first bit
            rise_cnt_ff <= 5'h00;
            if (int_mode) begin
               dout_ff <= fifo_empty ? 1'b0 : cur_byte[7];
            end else begin
               ext_word_ff <= ext_word_nxt;
               dout_ff <= ext_word_nxt[15];
            end
         end else if (in_frame) begin
            if (sclk_rise) begin
               // only the first sixteen bits form the word
               if (rise_cnt_ff < `ADCSC_FRAME_BITS) begin
                  shift_in_ff <= {shift_in_ff[14:0], din_s_ff};
               end
               if (rise_cnt_ff != `ADCSC_CNT_MAX) begin
                  rise_cnt_ff <= rise_cnt_ff + 5'h01;
               end
            end
            if (sclk_fall && (rise_cnt_ff != 5'h00)) begin
               dout_ff <= nxt_bit;
            end
         end else begin
            dout_ff <= 1'b0;
         end
      end
   end

   // fifo pointers: overwrite advances the read side too
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         {wptr_ff, rptr_ff} <= 8'h00;
         count_ff <= 5'h00;
         byte_hi_ff <= 1'b1;
      end else if (soft_rst) begin
         // soft reset drops every stored result
         {wptr_ff, rptr_ff} <= 8'h00;
         count_ff <= 5'h00;
         byte_hi_ff <= 1'b1;
      end else begin
         if (byte_used) begin
            byte_hi_ff <= ~byte_hi_ff;
         end
         if (push) begin
            wptr_ff <= wptr_ff + 4'h1;
         end
         if (push && (pop || fifo_full)) begin
            rptr_ff <= rptr_ff + 4'h1;
            if (fifo_full && !pop) begin
               byte_hi_ff <= 1'b1;    // oldest word gone, restart its byte
            end
         end else if (pop) begin
            rptr_ff <= rptr_ff + 4'h1;
         end
         if (push && !pop && !fifo_full) begin
            count_ff <= count_ff + 5'h01;
         end else if (pop && !push) begin
            count_ff <= count_ff - 5'h01;
         end
      end
   end

   // mode word, channel for the next external frame, config strobe
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mode_word_ff <= `ADCSC_MODE_RESET;
         ext_chan_ff <= 4'h0;
         {cfg_wr_ff, cfg_addr_ff, cfg_data_ff} <= 16'h0000;
      end else begin
         cfg_wr_ff <= is_cfg_wr;
         if (is_cfg_wr) begin
            cfg_addr_ff <= shift_in_ff[`ADCSC_CFG_ADDR_HI:`ADCSC_CFG_ADDR_LO];
            cfg_data_ff <= shift_in_ff[`ADCSC_CFG_DATA_HI:0];
         end
         if (soft_rst) begin
            mode_word_ff <= `ADCSC_MODE_RESET;
         end else if (is_mode_wr) begin
            mode_word_ff <= shift_in_ff;
            ext_chan_ff <= shift_in_ff[`ADCSC_MODE_CHAN_HI:`ADCSC_MODE_CHAN_LO];
         end else if (scan_done) begin
            mode_word_ff[`ADCSC_MODE_SOFT_CONVERT_BIT] <= 1'b0;
         end
      end
   end

   // scan engine: optional delay, then one timed conversion per channel
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_ff <= ST_IDLE;
         {timer_ff, scan_chan_ff} <= 8'h00;
         {ana_chan_ff, ana_sample_ff} <= 5'h00;
      end else begin
         ana_sample_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (cs_fall && !int_mode) begin
                  ana_sample_ff <= 1'b1;
               end
               if (is_mode_wr && !soft_rst) begin
                  ana_chan_ff <= shift_in_ff[`ADCSC_MODE_CHAN_HI:`ADCSC_MODE_CHAN_LO];
               end
               if (is_mode_wr && shift_in_ff[`ADCSC_MODE_SOFT_CONVERT_BIT] && !soft_rst &&
                   (shift_in_ff[`ADCSC_MODE_SCAN_HI:`ADCSC_MODE_SCAN_LO]
                    != `ADCSC_SCAN_MANUAL)) begin
                  state_ff <= ST_DELAY;
                  timer_ff <= 4'h0;
               end else if (cnv_fall && cs_s_ff && int_mode) begin
                  state_ff <= ST_CONV;
                  timer_ff <= 4'h0;
                  scan_chan_ff <= 4'h0;
                  ana_chan_ff <= 4'h0;
                  ana_sample_ff <= 1'b1;
               end
            end
            ST_DELAY: begin
               // delay from chip select rise before the scan begins
               if (timer_ff == SOFT_CONVERT_BIT_CYC - 4'h1) begin
                  state_ff <= ST_CONV;
                  timer_ff <= 4'h0;
                  scan_chan_ff <= 4'h0;
                  ana_chan_ff <= 4'h0;
                  ana_sample_ff <= 1'b1;
               end else begin
                  timer_ff <= timer_ff + 4'h1;
               end
            end
            ST_CONV: begin
               // each result takes sixteen oscillator periods
               if (conv_end) begin
                  timer_ff <= 4'h0;
                  if (scan_done) begin
                     state_ff <= ST_IDLE;
                     ana_chan_ff <= ext_chan_ff;
                  end else begin
                     scan_chan_ff <= scan_chan_ff + 4'h1;
                     ana_chan_ff <= scan_chan_ff + 4'h1;
                     ana_sample_ff <= 1'b1;
                  end
               end else begin
                  timer_ff <= timer_ff + 4'h1;
               end
            end
            default: begin
               state_ff <= ST_IDLE;
               timer_ff <= 4'h0;
            end
         endcase
      end
   end

   // end-of-conversion flag: the finishing scan wins over a new frame
   always @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         eoc_n_ff <= 1'b1;
      end else if (scan_done) begin
         eoc_n_ff <= 1'b0;
      end else if (cs_fall || cnv_fall) begin
         eoc_n_ff <= 1'b1;
      end
   end
endmodule // adcsc_top

/* tb/adcsc_properties.sv */
/*
 * checker of the serial conversion control top: timing relations between
 * the pins, the sample strobe and the end-of-conversion flag.
 * assumes one clock domain, clk_sys, and the asynchronous reset input.
 */
module adcsc_props (
   input logic clk_sys,
   input logic reset,
   input logic sclk,
   input logic cs_n,
   input logic convert_start_n,
   input logic dout_ff,
   input logic dout_oe_ff,
   input logic eoc_n_ff,
   input logic ana_sample_ff,
   input logic cfg_wr_ff,
   input logic [15:0] mode_word_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // a released pin carries no data
   oe_quiet_out_a: assert property (!dout_oe_ff |-> !dout_ff)
      else $error("dout set while released");
   // pin synchronisers give a few cycles of lag only
   oe_on_select_a: assert property ($fell(cs_n) |-> ##[2:5] dout_oe_ff)
      else $error("dout not driven after select");
   oe_off_idle_a: assert property (cs_n [*6] |-> !dout_oe_ff)
      else $error("dout driven while deselected");
   sample_single_a: assert property (ana_sample_ff |=> !ana_sample_ff)
      else $error("sample strobe too long");
   cfg_single_a: assert property (cfg_wr_ff |=> !cfg_wr_ff)
      else $error("config strobe too long");
   ext_sample_a: assert property ($fell(cs_n) && mode_word_ff[14:11] == 4'h1
      |-> ##[2:5] ana_sample_ff)
      else $error("no sample at frame start");
   scan_start_a: assert property ($fell(convert_start_n) && cs_n
      && mode_word_ff[14:11] != 4'h1 |-> ##[2:5] ana_sample_ff)
      else $error("no scan after start pulse");
   // the flag may only be released by a select or a start request
   eoc_hold_a: assert property ($rose(eoc_n_ff) |-> !cs_n || !convert_start_n)
      else $error("end flag released on its own");
   eoc_after_scan_a: assert property ($fell(eoc_n_ff) |-> $past(ana_sample_ff, 4)
      || $past(ana_sample_ff, 5) || $past(ana_sample_ff, 6))
      else $error("end flag without conversion");
   // output bits move only just after a serial clock fall
   dout_on_fall_a: assert property ($changed(dout_ff) && dout_oe_ff && $past(dout_oe_ff)
      |-> !$past(sclk, 2))
      else $error("dout moved outside a clock fall");
endmodule // adcsc_props

bind adcsc_top adcsc_props adcsc_props_inst (
   .clk_sys(clk_sys),
   .reset(reset),
   .sclk(sclk),
   .cs_n(cs_n),
   .convert_start_n(convert_start_n),
   .dout_ff(dout_ff),
   .dout_oe_ff(dout_oe_ff),
   .eoc_n_ff(eoc_n_ff),
   .ana_sample_ff(ana_sample_ff),
   .cfg_wr_ff(cfg_wr_ff),
   .mode_word_ff(mode_word_ff)
);

/* tb/adcsc_host.sv */
/*
 * serial host model: mode-3 master with an 800 ns serial clock and a
 * conversion start pin. all pin moves sit on falling system clock edges.
 * assumes the caller waits on the end flag between scans.
 */
module adcsc_host (
   input logic clk_sys,
   input logic dout_ff,
   output logic sclk,
   output logic cs_n,
   output logic din,
   output logic convert_start_n
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle: clock high, deselected, no start request
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
      convert_start_n = 1'b1;
   end

   // wait n falling edges of the system clock
   task automatic nclk(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // one frame: a word out msb first, a word captured at each rise
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      nclk(8); // clock held high a full period before select
      cs_n = 1'b0;
      nclk(8);
      for (int i = 15; i >= 0; i--) begin // sixteen clocks per word
         sclk = 1'b0;
         din = w[i];
         nclk(4);
         r[i] = dout_ff; // taken as the clock rises
         sclk = 1'b1;
         nclk(4);
      end
      sclk = 1'b0; // one clock past the word; the frame engine captures nothing on it
      nclk(4);
      sclk = 1'b1;
      nclk(4);
      nclk(4);
      cs_n = 1'b1;
      din = ~din; // a released line shows no stale value
      nclk(8);
   endtask

   // start pulse of six system clocks; checks neither select nor the end flag
   task automatic start_scan();
      convert_start_n = 1'b0;
      nclk(6);
      convert_start_n = 1'b1;
   endtask
endmodule // adcsc_host

/* tb/adc_serial_conversion_control_test.sv */
/*
 * testbench of the serial conversion control top: external frames, word
 * formats, config writes, internal scans, fifo overwrite and soft start.
 * assumes the host model for the pins and a toy analog core below.
 */
module adc_serial_conversion_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, reset, sclk, cs_n, din, convert_start_n;
   logic ana_below, ana_bipolar, res_10bit;
   logic dout_ff, dout_oe_ff, eoc_n_ff, ana_sample_ff, cfg_wr_ff;
   logic [11:0] ana_code;
   logic [3:0] ana_chan_ff, cfg_addr_ff;
   logic [10:0] cfg_data_ff;
   logic [15:0] mode_word_ff, rd;
   logic [3:0] gen; // marks which pass produced a code
   int n_mismatch = 0, n_checks = 0, cyc = 0, n_cfg = 0;

   adcsc_top adcsc_top_inst (.clk_sys(clk_sys), .reset(reset), .sclk(sclk), .cs_n(cs_n),
      .din(din), .convert_start_n(convert_start_n), .ana_code(ana_code),
      .ana_below(ana_below), .ana_bipolar(ana_bipolar), .res_10bit(res_10bit),
      .dout_ff(dout_ff), .dout_oe_ff(dout_oe_ff), .eoc_n_ff(eoc_n_ff),
      .ana_chan_ff(ana_chan_ff), .ana_sample_ff(ana_sample_ff), .cfg_wr_ff(cfg_wr_ff),
      .cfg_addr_ff(cfg_addr_ff), .cfg_data_ff(cfg_data_ff), .mode_word_ff(mode_word_ff));
   adcsc_host adcsc_host_inst (.clk_sys(clk_sys), .dout_ff(dout_ff), .sclk(sclk),
      .cs_n(cs_n), .din(din), .convert_start_n(convert_start_n));

   // clock and cycle ceiling; a hang counts as a mismatch
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
   end
   // toy analog core: code tells pass and channel apart
   always @(negedge clk_sys) ana_code <= {gen, ana_chan_ff, 4'ha};
   always @(posedge clk_sys) if (cfg_wr_ff === 1'b1) n_cfg <= n_cfg + 1;

   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bounded wait for the end flag
   task automatic wait_eoc();
      for (int k = 0; k < 300 && eoc_n_ff !== 1'b0; k++) @(negedge clk_sys);
      check("eoc", 16'(eoc_n_ff), 16'h0000);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      reset = 1'b1;
      {ana_below, ana_bipolar, res_10bit} = 3'h0;
      gen = 4'h1;
      repeat (12) @(negedge clk_sys);
      reset = 1'b0;
      check("mode rst", mode_word_ff, 16'h0800);
      check("oe rst", 16'(dout_oe_ff), 16'h0000);
      $display("test reset done");
      // external manual frames on channel 3
      adcsc_host_inst.xfer(16'h0980, rd);
      check("mode", mode_word_ff, 16'h0980);
      adcsc_host_inst.xfer(16'h0984, rd);
      check("tag off", rd, {1'b0, 12'h13a, 3'h0});
      adcsc_host_inst.xfer(16'h0984, rd);
      check("tag on", rd, {4'h3, 12'h13a});
      {ana_below, res_10bit} = 2'h3;
      adcsc_host_inst.xfer(16'h0984, rd);
      check("below", rd, {4'h3, 12'h000});
      ana_bipolar = 1'b1;
      adcsc_host_inst.xfer(16'hb0a5, rd);
      check("ten bit", rd, {4'h3, 12'h138});
      check("cfg n", 16'(n_cfg), 16'h0001);
      check("cfg a", 16'(cfg_addr_ff), 16'h0006);
      check("cfg d", 16'(cfg_data_ff), 16'h00a5);
      check("cfg mode", mode_word_ff, 16'h0984);
      {ana_below, ana_bipolar, res_10bit} = 3'h0;
      adcsc_host_inst.xfer(16'h0040, rd);
      check("soft rst", mode_word_ff, 16'h0800);
      $display("test external done");
      // internal scan of channels 0..2, then an empty read
      adcsc_host_inst.xfer(16'h1900, rd);
      adcsc_host_inst.start_scan();
      wait_eoc();
      for (int k = 0; k < 4; k++) begin
         adcsc_host_inst.xfer(16'h1900, rd);
         check("fifo", rd, k < 3 ? {k[3:0], gen, k[3:0], 4'ha} : 16'h0000);
         check("eoc rel", 16'(eoc_n_ff), 16'h0001);
      end
      $display("test scan done");
      // two full scans: the second overwrites every stored result
      adcsc_host_inst.xfer(16'h1f80, rd);
      adcsc_host_inst.start_scan();
      wait_eoc();
      gen = 4'h2;
      adcsc_host_inst.start_scan();
      wait_eoc();
      for (int k = 0; k < 17; k++) begin
         adcsc_host_inst.xfer(16'h1f80, rd);
         check("ovr", rd, k < 16 ? {k[3:0], gen, k[3:0], 4'ha} : 16'h0000);
      end
      $display("test overwrite done");
      // soft start bit: delay after select rise, scan, bit cleared
      adcsc_host_inst.xfer(16'h1902, rd);
      wait_eoc();
      check("soft_convert_bit clr", mode_word_ff, 16'h1900);
      adcsc_host_inst.xfer(16'h1900, rd);
      check("soft_convert_bit res", rd, {4'h0, gen, 4'h0, 4'ha});
      $display("test soft start done");
      wrap_up();
   end
endmodule // adc_serial_conversion_control_test
